// *** logic/pssl_pkg.sv ***
// Summary of operation
// [R1] events gather in an 8-bit packet sent every 1 to 10 us
// [R2] line stays low between packets until the interval expires
// [R3] interval expiry starts a packet with two high clocks
// [R4] eight packet bits follow one per clock, bit 7 first
// [R5] one high stop clock, then low until the next interval
// [R6] sent packet bits are cleared once the packet completes
// [R7] each marker or bit lasts one clock of the shared reference
// [R8] a set event bit stays set until the next packet completes
// [R9] repeats of an already flagged event change nothing
// [R10] distinct events each set their own bit and accumulate
// [R11] send only when interval expired and some bit is set
// [R12] receiver decodes each packet after its stop marker
// [R13] bit 7 flags a vertical sync pulse of the video output
// [R14] video bit sets in the same cycle as the vertical flag
// [R15] bit 6 flags a data cache miss, gated by its own enable
// [R16] receiver interrupt is a level held until its source clears
// [R17] bit 1 flags a memory address hit under base and mask
// [R18] receiver raises an interrupt on video bit when enabled
// [R19] receiver shows a status bit for a video retrace interrupt
// [R20] receiver needs two high samples after low to start
// [R21] receiver ignores bits 5..2 and 0, idles on bad stop
package pssl_pkg;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS   = 25;
   localparam int INTERVAL_NS     = 5000;
   localparam int INTERVAL_CYCLES = INTERVAL_NS / CLK_PERIOD_NS;
   localparam logic [7:0] INTERVAL_RELOAD = 8'(INTERVAL_CYCLES - 1);

   // ------------------------------------------------------------
   // packet layout
   // ------------------------------------------------------------
   localparam int PKT_W       = 8;
   localparam int BIT_VIDEO   = 7;
   localparam int BIT_MISS    = 6;
   localparam int BIT_DECODE  = 1;
   localparam int ADDR_W      = 32;
   localparam logic [2:0] LAST_BIT_IDX = 3'h7;
   localparam logic [7:0] PKT_EMPTY    = 8'h00;

   typedef enum logic [2:0] {
      ST_IDLE, ST_START1, ST_START2, ST_DATA, ST_STOP
   } pssl_state_t;

   typedef struct packed {
      pssl_state_t        st;
      logic [7:0]         interval;
      logic [2:0]         bits_left;
      logic [PKT_W-1:0]   shift;
      logic [PKT_W-1:0]   pkt;
      logic [PKT_W-1:0]   sent;
      logic               line;
      logic               vflag;
      logic               done;
   } pssl_regs_t;

endpackage : pssl_pkg

// *** logic/pssl_tx.sv ***
`timescale 1ns/10ps
module pssl_tx (
   input  wire logic                          SYS_CLK,           // 40 MHz
   input  wire logic                          RST_N,             // async reset
   input  wire logic                          VSYNC_EVENT,       // vsync pulse
   input  wire logic                          VERT_INT_ENABLE,   // flag enable
   input  wire logic                          VERT_INT_CLEAR,    // flag clear
   input  wire logic                          MISS_EVENT,        // l1 miss
   input  wire logic                          MISS_IS_FETCH,     // fetch miss
   input  wire logic                          POWER_MGMT_EVENT_ENABLE, // gate
   input  wire logic                          MEM_ACCESS,        // access strb
   input  wire logic [pssl_pkg::ADDR_W-1:0]   MEM_ADDR,          // address
   input  wire logic [pssl_pkg::ADDR_W-1:0]   DECODE_BASE_VALUE, // base
   input  wire logic [pssl_pkg::ADDR_W-1:0]   DECODE_MASK_VALUE, // mask
   output logic                               PROC_STATUS_SERIAL_LINE, // out
   output logic                               VERTICAL_INTERRUPT_FLAG, // flag
   output logic                               PACKET_DONE        // pulse
);

   // ------------------------------------------------------------
   // event decode
   // ------------------------------------------------------------
   function automatic logic addr_hit(input logic [pssl_pkg::ADDR_W-1:0] a,
                                     input logic [pssl_pkg::ADDR_W-1:0] b,
                                     input logic [pssl_pkg::ADDR_W-1:0] m);
      addr_hit = (((a ^ b) & m) == '0);
   endfunction : addr_hit

   pssl_pkg::pssl_regs_t        s;
   pssl_pkg::pssl_regs_t        next_s;
   logic [pssl_pkg::PKT_W-1:0]  ev;
   logic                        expired;
   logic                        start_now;

   // each source owns one bit, so distinct events accumulate
   always_comb begin
      ev = pssl_pkg::PKT_EMPTY;
      ev[pssl_pkg::BIT_VIDEO]  = VSYNC_EVENT;                        // R13
      ev[pssl_pkg::BIT_MISS]   = MISS_EVENT && !MISS_IS_FETCH &&
                                 POWER_MGMT_EVENT_ENABLE;             // R15
      ev[pssl_pkg::BIT_DECODE] = MEM_ACCESS &&
                                 addr_hit(MEM_ADDR, DECODE_BASE_VALUE,
                                          DECODE_MASK_VALUE);         // R17
   end

   assign expired   = (s.interval == 8'h00);
   assign start_now = (s.st == pssl_pkg::ST_IDLE) && expired &&
                      (s.pkt != pssl_pkg::PKT_EMPTY);                 // R11

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      next_s = s;
      next_s.done = 1'b0;
      // or-in makes repeats harmless and bits sticky
      next_s.pkt = s.pkt | ev;                                  // R8 R9 R10
      // flag sets with the video bit; set wins over clear
      next_s.vflag = VSYNC_EVENT | (s.vflag & ~VERT_INT_CLEAR);       // R14
      case (s.st)
         pssl_pkg::ST_IDLE: begin
            next_s.line = 1'b0;                                       // R2
            if (!expired) begin
               next_s.interval = s.interval - 8'h01;                  // R1
            end
            if (start_now) begin
               next_s.st    = pssl_pkg::ST_START1;
               next_s.line  = 1'b1;                                   // R3
               next_s.shift = s.pkt;
               next_s.sent  = s.pkt;
            end
         end
         pssl_pkg::ST_START1: begin
            next_s.st   = pssl_pkg::ST_START2;
            next_s.line = 1'b1;                                       // R3
         end
         pssl_pkg::ST_START2: begin
            next_s.st        = pssl_pkg::ST_DATA;
            next_s.line      = s.shift[pssl_pkg::PKT_W-1];            // R4
            next_s.shift     = {s.shift[pssl_pkg::PKT_W-2:0], 1'b0};
            next_s.bits_left = pssl_pkg::LAST_BIT_IDX;
         end
         pssl_pkg::ST_DATA: begin
            // one bit per clock of the shared reference
            if (s.bits_left == 3'h0) begin
               next_s.st   = pssl_pkg::ST_STOP;
               next_s.line = 1'b1;                                    // R5
            end else begin
               next_s.line      = s.shift[pssl_pkg::PKT_W-1];         // R4 R7
               next_s.shift     = {s.shift[pssl_pkg::PKT_W-2:0], 1'b0};
               next_s.bits_left = s.bits_left - 3'h1;
            end
         end
         pssl_pkg::ST_STOP: begin
            next_s.st       = pssl_pkg::ST_IDLE;
            next_s.line     = 1'b0;                                   // R5
            next_s.interval = pssl_pkg::INTERVAL_RELOAD;              // R1
            next_s.done     = 1'b1;
            // only sent bits clear, so mid-frame events on unsent bits survive
            next_s.pkt      = (s.pkt & ~s.sent) | ev;                 // R6
         end
         default: begin
            next_s.st   = pssl_pkg::ST_IDLE;
            next_s.line = 1'b0;
         end
      endcase
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         s           <= '0;
         s.st        <= pssl_pkg::ST_IDLE;
         s.interval  <= pssl_pkg::INTERVAL_RELOAD;
      end else begin
         s <= next_s;
      end
   end

   assign PROC_STATUS_SERIAL_LINE = s.line;
   assign VERTICAL_INTERRUPT_FLAG = s.vflag;
   assign PACKET_DONE             = s.done;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   logic pkt7;
   logic pkt0;
   assign pkt7 = s.pkt[pssl_pkg::BIT_VIDEO];
   assign pkt0 = s.pkt[0];

   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);

   sequence start_mark_s;
      s.line [*2];
   endsequence
   sequence stop_mark_s;
      s.line ##1 !s.line;
   endsequence

   idle_line_low_a: assert property ( // R2
      (s.st == pssl_pkg::ST_IDLE) |-> !s.line)
      else $error("line high while idle");
   start_marker_a: assert property ( // R3
      start_now |=> start_mark_s ##1 (s.st == pssl_pkg::ST_DATA))
      else $error("start marker not two clocks");
   first_bit_a: assert property ( // R4
      start_now |-> ##3 (s.line == $past(pkt7, 3)))
      else $error("first data bit not msb");
   last_bit_a: assert property ( // R7
      start_now |-> ##10 (s.line == $past(pkt0, 10)))
      else $error("last data bit wrong or mistimed");
   stop_marker_a: assert property ( // R5
      start_now |-> ##11 stop_mark_s)
      else $error("stop marker missing");
   sent_cleared_a: assert property ( // R6
      (s.st == pssl_pkg::ST_STOP) && (ev == '0) |=>
      ((s.pkt & $past(s.sent)) == '0))
      else $error("sent bits not cleared");
   empty_no_start_a: assert property ( // R11
      (s.st == pssl_pkg::ST_IDLE) && (s.pkt == '0) |=>
      (s.st == pssl_pkg::ST_IDLE))
      else $error("packet started while empty");
   early_no_start_a: assert property ( // R1
      (s.st == pssl_pkg::ST_IDLE) && !expired |=> !s.line)
      else $error("packet before interval expired");
   sticky_bits_a: assert property ( // R8
      (s.st != pssl_pkg::ST_STOP) |=> ((s.pkt & $past(s.pkt)) ==
                                       $past(s.pkt)))
      else $error("event bit dropped early");
   events_set_a: assert property ( // R10
      (ev != '0) |=> ((s.pkt & $past(ev)) == $past(ev)))
      else $error("event not accumulated");
   video_same_a: assert property ( // R14
      VSYNC_EVENT |=> (s.vflag && pkt7))
      else $error("video bit and flag disagree");
   miss_gate_a: assert property ( // R15
      MISS_EVENT && (MISS_IS_FETCH || !POWER_MGMT_EVENT_ENABLE) &&
      !s.pkt[pssl_pkg::BIT_MISS] && (s.st != pssl_pkg::ST_STOP) |=>
      !s.pkt[pssl_pkg::BIT_MISS])
      else $error("miss bit set without cause");

   // ------------------------------------------------------------
   // frame sequencing checks
   // ------------------------------------------------------------
   // eight data clocks, then the stop clock, then idle with the done pulse
   sequence data_phase_s;
      (s.st == pssl_pkg::ST_DATA) [*8];
   endsequence
   sequence frame_end_s;
      ((s.st == pssl_pkg::ST_STOP) && s.line) ##1
      ((s.st == pssl_pkg::ST_IDLE) && s.done);
   endsequence

   data_phase_a: assert property ( // R4
      start_now |-> ##3 data_phase_s ##1 frame_end_s)
      else $error("data phase not eight clocks");

   start_high_a: assert property ( // R3
      (s.st == pssl_pkg::ST_START1) || (s.st == pssl_pkg::ST_START2)
      |-> s.line)
      else $error("start marker low");

   // the frame works on a copy, so new events cannot disturb it
   shift_load_a: assert property ( // R4
      start_now |=> (s.shift == $past(s.pkt)))
      else $error("frame not loaded from packet");

   bit_count_a: assert property ( // R4
      (s.st == pssl_pkg::ST_START2) |=>
      (s.bits_left == pssl_pkg::LAST_BIT_IDX))
      else $error("bit counter not loaded");

   // exactly one bit leaves per clock, so the line rate is the clock
   bit_step_a: assert property ( // R7
      (s.st == pssl_pkg::ST_DATA) && (s.bits_left != 3'h0) |=>
      (s.st == pssl_pkg::ST_DATA) &&
      (s.bits_left == $past(s.bits_left) - 3'h1))
      else $error("more than one bit per clock");

   stop_idle_a: assert property ( // R5
      (s.st == pssl_pkg::ST_STOP) |=> (s.st == pssl_pkg::ST_IDLE) && !s.line)
      else $error("line not low after stop");

   done_pulse_a: assert property ( // R6
      s.done |=> !s.done)
      else $error("done longer than one clock");

   // ------------------------------------------------------------
   // interval checks
   // ------------------------------------------------------------
   // the counter freezes during a frame and reloads at stop, so the
   // gap between frames never falls below the reload count
   interval_reload_a: assert property ( // R1
      (s.st == pssl_pkg::ST_STOP) |=>
      (s.interval == pssl_pkg::INTERVAL_RELOAD))
      else $error("interval not reloaded");

   interval_step_a: assert property ( // R1
      (s.st == pssl_pkg::ST_IDLE) && !expired |=>
      (s.interval == $past(s.interval) - 8'h01))
      else $error("interval not counting down");

   interval_frozen_a: assert property ( // R1
      (s.st != pssl_pkg::ST_IDLE) && (s.st != pssl_pkg::ST_STOP) |=>
      $stable(s.interval))
      else $error("interval moved during frame");

   expired_hold_a: assert property ( // R11
      (s.st == pssl_pkg::ST_IDLE) && expired && (s.pkt == '0) |=>
      expired && !s.line)
      else $error("interval left zero while empty");

   // ------------------------------------------------------------
   // packet and flag checks
   // ------------------------------------------------------------
   // reserved bits have no source; a set one means a stray write
   localparam logic [pssl_pkg::PKT_W-1:0] USED_BITS =
      (8'h01 << pssl_pkg::BIT_VIDEO) | (8'h01 << pssl_pkg::BIT_MISS) |
      (8'h01 << pssl_pkg::BIT_DECODE);

   reserved_clear_a: assert property ( // R10
      (s.pkt & ~USED_BITS) == pssl_pkg::PKT_EMPTY)
      else $error("reserved packet bit set");

   // a repeat of a flagged event must leave the register untouched
   repeat_ignored_a: assert property ( // R9
      ((ev & s.pkt) == ev) && (s.st != pssl_pkg::ST_STOP) |=>
      (s.pkt == $past(s.pkt)))
      else $error("repeated event changed packet");

   miss_set_a: assert property ( // R15
      MISS_EVENT && !MISS_IS_FETCH && POWER_MGMT_EVENT_ENABLE |=>
      s.pkt[pssl_pkg::BIT_MISS])
      else $error("data miss not flagged");

   // the hit rule is restated here rather than using the decode function
   decode_hit_a: assert property ( // R17
      MEM_ACCESS &&
      (((MEM_ADDR ^ DECODE_BASE_VALUE) & DECODE_MASK_VALUE) == '0) |=>
      s.pkt[pssl_pkg::BIT_DECODE])
      else $error("decode hit not flagged");

   decode_quiet_a: assert property ( // R17
      !MEM_ACCESS && !s.pkt[pssl_pkg::BIT_DECODE] |=>
      !s.pkt[pssl_pkg::BIT_DECODE])
      else $error("decode bit set without access");

   // the flag enable drives no logic here, so it never gates the flag itself
   flag_clear_a: assert property ( // R14
      VERT_INT_CLEAR && !VSYNC_EVENT |=> !s.vflag)
      else $error("vertical flag not cleared");

   flag_hold_a: assert property ( // R14
      s.vflag && !VERT_INT_CLEAR |=> s.vflag)
      else $error("vertical flag dropped");

   flag_ungated_a: assert property ( // R14
      VSYNC_EVENT && !VERT_INT_ENABLE |=> s.vflag && pkt7)
      else $error("video bit gated by flag enable");

   video_only_a: assert property ( // R13
      !VSYNC_EVENT && !pkt7 |=> !pkt7)
      else $error("video bit set without vsync");

endmodule : pssl_tx

// *** verification/pssl_rx_model.sv ***
`timescale 1ns/10ps
// companion side: decodes frames and raises a level interrupt
module pssl_rx_model (
   input  wire logic       clk,     // shared reference clock
   input  wire logic       rst_n,   // async reset
   input  wire logic       line,    // serial status line
   input  wire logic       rtr_en,  // retrace interrupt enable
   input  wire logic       clr,     // software clears the source
   output logic [7:0]      pkt,     // last good packet
   output logic            vld,     // pulse per good packet
   output logic            smi_n,   // level interrupt, active low
   output logic            rtr_st   // retrace caused the interrupt
);
   logic [3:0] ph;
   logic       prev;
   logic [7:0] sh;
   // one sample a clock; prev starts high so a stuck line fakes no start
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         {ph, prev, sh, pkt, vld, smi_n, rtr_st} <= 24'h080002;
      end else begin
         prev <= line;
         vld  <= 1'b0;
         if (clr) begin
            smi_n  <= 1'b1;
            rtr_st <= 1'b0;
         end
         if (ph == 4'h0) begin
            ph <= {3'h0, line & ~prev};
         end else if (ph == 4'h1) begin
            ph <= line ? 4'h2 : 4'h0;
         end else if (ph < 4'ha) begin
            sh <= {sh[6:0], line};
            ph <= ph + 4'h1;
         end else begin
            ph <= 4'h0;
            if (line) begin
               pkt <= sh;
               vld <= 1'b1;
               // only the video bit matters here, the rest is ignored
               if (sh[7] & rtr_en) begin
                  smi_n  <= 1'b0;
                  rtr_st <= 1'b1;
               end
            end
         end
      end
   end
endmodule : pssl_rx_model

// *** verification/test_processor_status_serial_link.sv ***
`timescale 1ns/10ps
module test_processor_status_serial_link;
   logic SYS_CLK = 1'b0, RST_N = 1'b0, VSYNC_EVENT = 1'b0, MISS_EVENT = 1'b0;
   logic VERT_INT_CLEAR = 1'b0, MISS_IS_FETCH = 1'b0, MEM_ACCESS = 1'b0;
   logic VERT_INT_ENABLE = 1'b1, pm_en = 1'b1, rtr_en = 1'b1, clr = 1'b0;
   logic [31:0] MEM_ADDR = 32'h0;
   logic [31:0] base = 32'h0000_1000, mask = 32'hffff_f000;
   logic        line, vflag, done, vld, smi_n, rtr_st, seen;
   logic [7:0]  pkt;
   int          n_errors = 0, n_checks = 0, gap;
   // 40 MHz reference clock
   always #12.5 SYS_CLK = ~SYS_CLK;
   pssl_tx i_dut (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .VSYNC_EVENT(VSYNC_EVENT),
      .VERT_INT_ENABLE(VERT_INT_ENABLE), .VERT_INT_CLEAR(VERT_INT_CLEAR),
      .MISS_EVENT(MISS_EVENT), .MISS_IS_FETCH(MISS_IS_FETCH),
      .POWER_MGMT_EVENT_ENABLE(pm_en), .MEM_ACCESS(MEM_ACCESS),
      .MEM_ADDR(MEM_ADDR), .DECODE_BASE_VALUE(base),
      .DECODE_MASK_VALUE(mask), .PROC_STATUS_SERIAL_LINE(line),
      .VERTICAL_INTERRUPT_FLAG(vflag), .PACKET_DONE(done));
   pssl_rx_model i_rx (.clk(SYS_CLK), .rst_n(RST_N), .line(line),
      .rtr_en(rtr_en), .clr(clr), .pkt(pkt), .vld(vld), .smi_n(smi_n),
      .rtr_st(rtr_st));
   // ------------------------------------------------------------
   // access tasks
   // ------------------------------------------------------------
   task automatic tally_and_finish;
      if (n_errors == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : tally_and_finish
   task automatic chk(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // k is {vsync, miss, access, flag clear}, one cycle wide
   task automatic ev(input logic [3:0] k, input logic f, input logic [31:0] a);
      @(negedge SYS_CLK);
      {VSYNC_EVENT, MISS_EVENT, MEM_ACCESS, VERT_INT_CLEAR} = k;
      MISS_IS_FETCH = f;
      MEM_ADDR = a;
      @(negedge SYS_CLK);
      {VSYNC_EVENT, MISS_EVENT, MEM_ACCESS, VERT_INT_CLEAR} = 4'h0;
   endtask : ev
   // bounded wait; gap ends as cycles waited plus one
   task automatic wait_pkt(input int lim);
      seen = 1'b0;
      for (gap = 1; gap <= lim && !seen; gap++) begin
         @(negedge SYS_CLK);
         seen = (vld === 1'b1);
      end
      if (seen) chk("done pulse", 8'h1, {7'h0, done});
   endtask : wait_pkt
   task automatic expect_pkt(input logic [7:0] e);
      wait_pkt(400);
      chk("packet seen", 8'h1, {7'h0, seen});
      if (!seen) tally_and_finish();
      chk("packet", e, pkt);
   endtask : expect_pkt
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (5) @(negedge SYS_CLK);
      RST_N = 1'b1;
      wait_pkt(300);
      chk("idle packet", 8'h0, {7'h0, seen});
      chk("idle line", 8'h0, {7'h0, line});
      ev(4'h8, 1'b0, 32'h0);
      chk("video flag", 8'h1, {7'h0, vflag});
      // these land while the first frame is on the wire
      ev(4'h8, 1'b0, 32'h0);
      ev(4'h4, 1'b0, 32'h0);
      ev(4'h2, 1'b0, 32'h0000_1234);
      expect_pkt(8'h80);
      chk("smi", 8'h0, {7'h0, smi_n});
      chk("retrace st", 8'h1, {7'h0, rtr_st});
      expect_pkt(8'h42);
      chk("gap low", 8'h1, {7'h0, gap >= 200});
      chk("gap high", 8'h1, {7'h0, gap <= 400});
      chk("smi held", 8'h0, {7'h0, smi_n});
      @(negedge SYS_CLK);
      clr = 1'b1;
      @(negedge SYS_CLK);
      clr = 1'b0;
      chk("smi clear", 8'h1, {7'h0, smi_n});
      ev(4'h1, 1'b0, 32'h0);
      chk("flag clear", 8'h0, {7'h0, vflag});
      // the flag enable must not gate the flag or the video bit
      rtr_en = 1'b0;
      VERT_INT_ENABLE = 1'b0;
      ev(4'h8, 1'b0, 32'h0);
      chk("flag ungated", 8'h1, {7'h0, vflag});
      expect_pkt(8'h80);
      chk("smi masked", 8'h1, {7'h0, smi_n});
      // fetch miss, disabled miss and a decode miss set nothing
      ev(4'h4, 1'b1, 32'h0);
      pm_en = 1'b0;
      ev(4'h4, 1'b0, 32'h0);
      ev(4'h2, 1'b0, 32'h0000_2000);
      wait_pkt(450);
      chk("no packet", 8'h0, {7'h0, seen});
      pm_en = 1'b1;
      ev(4'h4, 1'b0, 32'h0);
      expect_pkt(8'h40);
      // an all-zero mask makes every access a decode hit
      mask = 32'h0;
      ev(4'h2, 1'b0, 32'h0000_5678);
      expect_pkt(8'h02);
      tally_and_finish();
   end
endmodule : test_processor_status_serial_link
